// ---- inc/dbgm_defs.svh ----
// register map and field constants of the debug and wait mode gating block
`ifndef DBGM_DEFS_SVH
`define DBGM_DEFS_SVH
// ***************************************************************
// register bus geometry
// ***************************************************************
`define DBGM_ADDR_W        4
`define DBGM_DATA_W        8
// ***************************************************************
// register offsets
// ***************************************************************
`define DBGM_OFS_FORCE     4'h1
`define DBGM_OFS_OPTS      4'h2
`define DBGM_OFS_STATUS    4'h3
// ***************************************************************
// field positions and reset values
// ***************************************************************
`define DBGM_BIT_FORCE     0
`define DBGM_BIT_DEEP_HALT 5
`define DBGM_OPTS_RST      8'h00
`define DBGM_RDATA_ZERO    8'h00
`define DBGM_ST_MODE_LO    0
`define DBGM_ST_SEEN       4
`endif

// ---- inc/dbgm_pkg.sv ----
// types and shared decode of the debug and wait mode gating block
package dbgm_pkg;
   // operating mode of the device
   typedef enum logic [2:0] {
      DBGM_BOOT,
      DBGM_RUN,
      DBGM_WAIT,
      DBGM_STOP,
      DBGM_DEBUG
   } dbgm_mode_e;

   // decoded class of a command from the single wire debug pin
   typedef enum logic [2:0] {
      DBGM_C_MEM,
      DBGM_C_MEM_STAT,
      DBGM_C_CTRL_REG,
      DBGM_C_ENTER_DBG,
      DBGM_C_CPU_RD,
      DBGM_C_CPU_WR,
      DBGM_C_STEP,
      DBGM_C_RESUME
   } dbgm_cmd_e;

   // true for commands that run alongside the user program
   function automatic logic dbgm_is_nonintr(input dbgm_cmd_e c);
      return (c == DBGM_C_MEM) || (c == DBGM_C_MEM_STAT) ||
             (c == DBGM_C_CTRL_REG) || (c == DBGM_C_ENTER_DBG);
   endfunction

   // true when a command may act in the given mode
   function automatic logic dbgm_allowed(input dbgm_mode_e m, input dbgm_cmd_e c);
      case (m)
         DBGM_DEBUG: return 1'b1;
         DBGM_RUN:   return dbgm_is_nonintr(c);
         DBGM_WAIT:  return (c == DBGM_C_ENTER_DBG) || (c == DBGM_C_MEM_STAT);
         DBGM_STOP:  return c == DBGM_C_MEM_STAT;
         default:    return 1'b0;
      endcase
   endfunction
endpackage

// ---- hw/dbgm_regs.sv ----
// software register port: force reset register, options, status
`timescale 1ns/1ps
`include "dbgm_defs.svh"
module dbgm_regs (
   input  wire logic                      i_mclk,
   input  wire logic                      i_resetn,
   input  wire logic [`DBGM_ADDR_W-1:0]   i_addr,
   input  wire logic [`DBGM_DATA_W-1:0]   i_wdata,
   input  wire logic                      i_wr,
   input  wire logic                      i_rd,
   input  wire logic [`DBGM_DATA_W-1:0]   i_status,
   output logic      [`DBGM_DATA_W-1:0]   o_rdata,
   output logic                           o_deep_halt_en,
   output logic                           o_force_wr
);
   import dbgm_pkg::*;

   logic [`DBGM_DATA_W-1:0] opts_reg;   // system options one image
   logic [`DBGM_DATA_W-1:0] rdata_reg;  // read data, one cycle late

   // ***************************************************************
   // options register
   // ***************************************************************
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         opts_reg <= `DBGM_OPTS_RST;
      end else if (i_wr && (i_addr == `DBGM_OFS_OPTS)) begin
         opts_reg <= i_wdata;
      end
   end

   // ***************************************************************
   // read port, unmapped and write-only offsets read zero
   // ***************************************************************
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         rdata_reg <= `DBGM_RDATA_ZERO;
      end else if (i_rd) begin
         case (i_addr)
            `DBGM_OFS_OPTS:   rdata_reg <= opts_reg;
            `DBGM_OFS_STATUS: rdata_reg <= i_status;
            default:          rdata_reg <= `DBGM_RDATA_ZERO;
         endcase
      end else begin
         rdata_reg <= `DBGM_RDATA_ZERO;
      end
   end

   assign o_rdata        = rdata_reg;
   assign o_deep_halt_en = opts_reg[`DBGM_BIT_DEEP_HALT];
   // one written to the force bit, never stored
   assign o_force_wr     = i_wr && (i_addr == `DBGM_OFS_FORCE) && i_wdata[`DBGM_BIT_FORCE];
endmodule // dbgm_regs

// ---- hw/dbgm_cmd_gate.sv ----
// mode-dependent admission of debug pin commands
`timescale 1ns/1ps
module dbgm_cmd_gate (
   input  wire logic                 i_valid,
   input  wire dbgm_pkg::dbgm_mode_e i_mode,
   input  wire dbgm_pkg::dbgm_cmd_e  i_cmd,
   output logic                      o_accept,
   output logic                      o_ignore,
   output logic                      o_low_pwr_err
);
   import dbgm_pkg::*;

   // ***************************************************************
   // admission decode
   // ***************************************************************
   always_comb begin
      o_accept      = i_valid && dbgm_allowed(i_mode, i_cmd);
      o_ignore      = i_valid && !dbgm_allowed(i_mode, i_cmd);
      // status reads in low power modes report instead of touching memory
      o_low_pwr_err = o_accept && (i_cmd == DBGM_C_MEM_STAT) &&
                      ((i_mode == DBGM_WAIT) || (i_mode == DBGM_STOP));
   end
endmodule // dbgm_cmd_gate

// ---- hw/dbgm_mode_ctrl.sv ----
// mode controller: debug entry, command gating, wait and stop modes
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps
`include "dbgm_defs.svh"
//
// Contract
// - mode select low at power-on enters debug
// - force bit, select low, after entry: debug reset
// - pin reset always restarts in user mode
// - run mode accepts non-intrusive commands
// - debug mode also runs non-intrusive commands
// - debug-only commands refused while program runs
// - debug: register access, step, resume
// - halt instruction enters wait, cpu unclocked
// - wait entry clears interrupt mask
// - interrupt wakes cpu into stacking sequence
// - wait accepts only entry and status commands
// - status commands in wait/stop report error
// - entry command in wait goes to debug
// - stop only when deep halt enabled
module dbgm_mode_ctrl (
   input  wire logic                    i_mclk,
   input  wire logic                    i_resetn,
   input  wire logic [`DBGM_ADDR_W-1:0] i_addr,
   input  wire logic [`DBGM_DATA_W-1:0] i_wdata,
   input  wire logic                    i_wr,
   input  wire logic                    i_rd,
   output logic      [`DBGM_DATA_W-1:0] o_rdata,
   input  wire logic                    i_mode_select_pin,
   input  wire logic                    i_pin_reset,
   input  wire logic                    i_cmd_valid,
   input  wire dbgm_pkg::dbgm_cmd_e     i_cmd,
   output logic                         o_cmd_accept,
   output logic                         o_cmd_ignore,
   input  wire logic                    i_wait_exec,
   input  wire logic                    i_stop_exec,
   input  wire logic                    i_irq,
   output logic                         o_core_reset,
   output logic                         o_cpu_clk_en,
   output logic                         o_bus_clk_en,
   output logic                         o_clear_imask,
   output logic                         o_stack_start,
   output logic                         o_active_debug_mode,
   output logic                         o_mem_access,
   output logic                         o_ctrl_reg_access,
   output logic                         o_cpu_reg_rd,
   output logic                         o_cpu_reg_wr,
   output logic                         o_step,
   output logic                         o_low_pwr_err
);
   import dbgm_pkg::*;

   // ***************************************************************
   // declarations
   // ***************************************************************
   dbgm_mode_e              mode_reg;       // current mode
   dbgm_mode_e              mode_next;      // next mode
   logic                    seen_reg;       // entry command issued
   logic                    core_rst_reg;   // core reset strobe
   logic                    imask_reg;      // clear mask strobe
   logic                    stack_reg;      // stacking start strobe
   logic                    mem_reg;        // memory access strobe
   logic                    ctrl_reg;       // controller register strobe
   logic                    cpurd_reg;      // cpu register read strobe
   logic                    cpuwr_reg;      // cpu register write strobe
   logic                    step_reg;       // single step strobe
   logic                    lperr_reg;      // low power error strobe
   logic                    accept;         // command admitted
   logic                    ignore;         // command refused
   logic                    lp_err;         // status read in low power
   logic                    deep_en;        // deep halt enable bit
   logic                    force_wr;       // force bit written with one
   logic                    force_go;       // qualified forced debug reset
   logic [`DBGM_DATA_W-1:0] status;         // software visible state

   // ***************************************************************
   // submodules
   // ***************************************************************
   dbgm_regs u_regs (
      .i_mclk         (i_mclk),
      .i_resetn       (i_resetn),
      .i_addr         (i_addr),
      .i_wdata        (i_wdata),
      .i_wr           (i_wr),
      .i_rd           (i_rd),
      .i_status       (status),
      .o_rdata        (o_rdata),
      .o_deep_halt_en (deep_en),
      .o_force_wr     (force_wr)
   );

   dbgm_cmd_gate u_gate (
      .i_valid       (i_cmd_valid),
      .i_mode        (mode_reg),
      .i_cmd         (i_cmd),
      .o_accept      (accept),
      .o_ignore      (ignore),
      .o_low_pwr_err (lp_err)
   );

   assign o_cmd_accept = accept;
   assign o_cmd_ignore = ignore;

   // status: mode code and entry flag
   always_comb begin
      status = `DBGM_RDATA_ZERO;
      status[`DBGM_ST_MODE_LO +: $bits(dbgm_mode_e)] = mode_reg;
      status[`DBGM_ST_SEEN] = seen_reg;
   end

   assign force_go = force_wr && !i_mode_select_pin && seen_reg;

   // ***************************************************************
   // mode transitions; pin reset, then forced reset, then the rest
   // ***************************************************************
   always_comb begin
      mode_next = mode_reg;
      case (mode_reg)
         DBGM_BOOT: begin
            mode_next = i_mode_select_pin ? DBGM_RUN : DBGM_DEBUG;
         end
         DBGM_RUN: begin
            if (accept && (i_cmd == DBGM_C_ENTER_DBG)) begin
               mode_next = DBGM_DEBUG;
            end else if (i_wait_exec) begin
               mode_next = DBGM_WAIT;
            end else if (i_stop_exec && deep_en) begin
               mode_next = DBGM_STOP;
            end
         end
         DBGM_WAIT: begin
            if (accept && (i_cmd == DBGM_C_ENTER_DBG)) begin
               mode_next = DBGM_DEBUG;
            end else if (i_irq) begin
               mode_next = DBGM_RUN;
            end
         end
         // stop exit by interrupt
         DBGM_STOP: begin
            if (i_irq) begin
               mode_next = DBGM_RUN;
            end
         end
         DBGM_DEBUG: begin
            if (accept && (i_cmd == DBGM_C_RESUME)) begin
               mode_next = DBGM_RUN;
            end
         end
         default: mode_next = DBGM_BOOT;
      endcase
      if (i_pin_reset) begin
         mode_next = DBGM_RUN;
      end else if (force_go) begin
         mode_next = DBGM_DEBUG;
      end
   end

   // mode register
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         mode_reg <= DBGM_BOOT;
      end else begin
         mode_reg <= mode_next;
      end
   end

   // entry-seen flag; a new entry command beats the clear
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         seen_reg <= 1'b0;
      end else if (accept && (i_cmd == DBGM_C_ENTER_DBG)) begin
         seen_reg <= 1'b1;
      end else if (force_go || i_pin_reset) begin
         seen_reg <= 1'b0;
      end
   end

   // core reset strobe for pin and forced resets
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         core_rst_reg <= 1'b1;
      end else begin
         core_rst_reg <= i_pin_reset || force_go;
      end
   end

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         imask_reg <= 1'b0;
         stack_reg <= 1'b0;
      end else begin
         imask_reg <= (mode_reg != DBGM_WAIT) && (mode_next == DBGM_WAIT);
         stack_reg <= (mode_reg != DBGM_RUN) && (mode_reg != DBGM_BOOT) &&
                      (mode_next == DBGM_RUN) && i_irq && !i_pin_reset;
      end
   end

   // ***************************************************************
   // command strobes
   // ***************************************************************
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         mem_reg   <= 1'b0;
         ctrl_reg  <= 1'b0;
         cpurd_reg <= 1'b0;
         cpuwr_reg <= 1'b0;
         step_reg  <= 1'b0;
         lperr_reg <= 1'b0;
      end else begin
         // no memory access in low power modes
         mem_reg   <= accept && !lp_err &&
                      ((i_cmd == DBGM_C_MEM) || (i_cmd == DBGM_C_MEM_STAT));
         ctrl_reg  <= accept && (i_cmd == DBGM_C_CTRL_REG);
         cpurd_reg <= accept && (i_cmd == DBGM_C_CPU_RD);
         cpuwr_reg <= accept && (i_cmd == DBGM_C_CPU_WR);
         step_reg  <= accept && (i_cmd == DBGM_C_STEP);
         lperr_reg <= lp_err;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign o_core_reset        = core_rst_reg;
   // cpu clock off in wait and stop
   assign o_cpu_clk_en        = (mode_reg == DBGM_RUN) || (mode_reg == DBGM_DEBUG);
   assign o_bus_clk_en        = (mode_reg != DBGM_STOP);
   assign o_clear_imask       = imask_reg;
   assign o_stack_start       = stack_reg;
   assign o_active_debug_mode = (mode_reg == DBGM_DEBUG);
   assign o_mem_access        = mem_reg;
   assign o_ctrl_reg_access   = ctrl_reg;
   assign o_cpu_reg_rd        = cpurd_reg;
   assign o_cpu_reg_wr        = cpuwr_reg;
   assign o_step              = step_reg;
   assign o_low_pwr_err       = lperr_reg;

   // ***************************************************************
   // assertions
   // ***************************************************************
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);

   AST_BOOT_STRAP: assert property (
      (mode_reg == DBGM_BOOT) && !i_mode_select_pin && !i_pin_reset
      |=> o_active_debug_mode)
      else $error("low strap did not enter debug");

   AST_FORCE_RST: assert property (
      force_wr && !i_mode_select_pin && seen_reg && !i_pin_reset
      |=> o_core_reset && o_active_debug_mode)
      else $error("forced reset did not reach debug");

   AST_PIN_USER: assert property (
      i_pin_reset |=> (mode_reg == DBGM_RUN) && o_core_reset)
      else $error("pin reset not in user mode");

   AST_RUN_NONINTR: assert property (
      (mode_reg == DBGM_RUN) && i_cmd_valid && dbgm_is_nonintr(i_cmd)
      |-> o_cmd_accept)
      else $error("non-intrusive command refused in run");

   AST_DEBUG_ALL: assert property (
      (mode_reg == DBGM_DEBUG) && i_cmd_valid |-> o_cmd_accept)
      else $error("command refused in debug");

   AST_RUN_REFUSE: assert property (
      (mode_reg == DBGM_RUN) && i_cmd_valid && !dbgm_is_nonintr(i_cmd)
      |-> o_cmd_ignore ##1 !(o_cpu_reg_rd || o_cpu_reg_wr || o_step))
      else $error("debug-only command acted in run");

   AST_RESUME: assert property (
      o_cmd_accept && (mode_reg == DBGM_DEBUG) && (i_cmd == DBGM_C_RESUME)
      && !i_pin_reset && !force_go |=> (mode_reg == DBGM_RUN))
      else $error("resume did not leave debug");

   AST_WAIT_ENTRY: assert property (
      (mode_reg == DBGM_RUN) && i_wait_exec && !i_cmd_valid && !i_pin_reset
      && !force_go |=> !o_cpu_clk_en && o_clear_imask)
      else $error("wait entry wrong");

   AST_WAIT_MASK: assert property (
      $rose(mode_reg == DBGM_WAIT) |-> o_clear_imask)
      else $error("mask not cleared on wait");

   AST_WAKE_IRQ: assert property (
      (mode_reg == DBGM_WAIT) && i_irq && !i_cmd_valid && !i_pin_reset
      && !force_go |=> o_stack_start && o_cpu_clk_en)
      else $error("interrupt did not wake cpu");

   AST_WAIT_ONLY: assert property (
      (mode_reg == DBGM_WAIT) && i_cmd_valid && (i_cmd != DBGM_C_ENTER_DBG)
      && (i_cmd != DBGM_C_MEM_STAT) |-> o_cmd_ignore)
      else $error("wait accepted a barred command");

   AST_LP_ERR: assert property (
      (mode_reg == DBGM_WAIT) && i_cmd_valid && (i_cmd == DBGM_C_MEM_STAT)
      |=> o_low_pwr_err && !o_mem_access)
      else $error("status read in wait touched memory");

   AST_WAKE_DBG: assert property (
      (mode_reg == DBGM_WAIT) && i_cmd_valid && (i_cmd == DBGM_C_ENTER_DBG)
      && !i_pin_reset |=> o_active_debug_mode)
      else $error("entry command did not wake to debug");

   AST_STOP_GATE: assert property (
      (mode_reg == DBGM_RUN) && i_stop_exec && !deep_en
      |=> (mode_reg != DBGM_STOP))
      else $error("stop entered while disabled");

   AST_IGNORE_QUIET: assert property (
      // boot always moves on at its first edge, refused command or not
      o_cmd_ignore && !i_pin_reset && !force_go && !i_wait_exec
      && !i_stop_exec && !i_irq && (mode_reg != DBGM_BOOT)
      |=> $stable(mode_reg) && !o_mem_access)
      else $error("ignored command changed state");

   AST_STOP_LP_ERR: assert property (
      (mode_reg == DBGM_STOP) && i_cmd_valid && (i_cmd == DBGM_C_MEM_STAT)
      |=> o_low_pwr_err && !o_mem_access)
      else $error("status read in stop touched memory");

   AST_STOP_ENTRY: assert property (
      (mode_reg == DBGM_RUN) && i_stop_exec && deep_en && !i_wait_exec
      && !i_cmd_valid && !i_pin_reset && !force_go
      |=> !o_bus_clk_en && !o_cpu_clk_en)
      else $error("enabled stop did not halt clocks");

   AST_STEP_STAY: assert property (
      o_cmd_accept && (mode_reg == DBGM_DEBUG) && (i_cmd == DBGM_C_STEP)
      && !i_pin_reset && !force_go |=> o_step && o_active_debug_mode)
      else $error("step left debug or gave no strobe");

   COV_BOOT_DEBUG: cover property ((mode_reg == DBGM_BOOT) ##1 o_active_debug_mode);
   COV_WAIT_IRQ:   cover property ((mode_reg == DBGM_WAIT) ##1 o_stack_start);
   COV_WAIT_DBG:   cover property ((mode_reg == DBGM_WAIT) ##1 o_active_debug_mode);
   COV_FORCE:      cover property (force_go ##1 o_core_reset);
   COV_STOP_IRQ:   cover property ((mode_reg == DBGM_STOP) ##1 o_stack_start);
endmodule // dbgm_mode_ctrl

// ---- verif/dbgm_host_model.sv ----
// debug host model: drives the mode select level and decoded debug commands
`timescale 1ns/1ps
module dbgm_host_model (
   input  wire logic           i_mclk,
   input  wire logic           i_cmd_accept,
   input  wire logic           i_cmd_ignore,
   output logic                o_mode_select_pin,
   output logic                o_cmd_valid,
   output dbgm_pkg::dbgm_cmd_e o_cmd
);
   import dbgm_pkg::*;

   // ***************************************************************
   // idle state at time zero
   // ***************************************************************
   initial begin
      o_mode_select_pin = 1'b1;
      o_cmd_valid       = 1'b0;
      o_cmd             = DBGM_C_MEM;
   end

   // level held steady
   // level changes only after an edge and then stays put, through any reset
   task automatic set_ms(input logic v);
      @(posedge i_mclk);
      o_mode_select_pin <= v;
   endtask

   // one command cycle; answer taken at the edge that takes the command
   task automatic send(input dbgm_cmd_e c, output logic acc, output logic ign);
      @(posedge i_mclk);
      o_cmd_valid <= 1'b1;
      o_cmd       <= c;
      @(posedge i_mclk);
      acc = i_cmd_accept;
      ign = i_cmd_ignore;
      o_cmd_valid <= 1'b0;
      // released class field shows a changed value, not the stale one
      o_cmd       <= dbgm_cmd_e'(~c);
   endtask
endmodule // dbgm_host_model

// ---- verif/dbgm_mode_ctrl_test.sv ----
// self-checking testbench of the debug and wait mode controller
`timescale 1ns/1ps
`include "dbgm_defs.svh"
`define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
   $display("unexpected %s: expected %h, seen %h", what, exp, got); end end
module dbgm_mode_ctrl_test;
   import dbgm_pkg::*;
   logic                    i_mclk = 1'b0;
   logic                    i_resetn = 1'b0;
   logic [`DBGM_ADDR_W-1:0] i_addr = 4'h0;
   logic [`DBGM_DATA_W-1:0] i_wdata = 8'h00;
   logic                    i_wr = 1'b0;
   logic                    i_rd = 1'b0;
   logic                    i_pin_reset = 1'b0;
   logic                    i_wait_exec = 1'b0;
   logic                    i_stop_exec = 1'b0;
   logic                    i_irq = 1'b0;
   logic [`DBGM_DATA_W-1:0] o_rdata;
   logic                    ms, cmd_valid, acc, ign;
   dbgm_cmd_e               cmd;
   logic                    o_cmd_accept, o_cmd_ignore, o_core_reset, o_cpu_clk_en;
   logic                    o_bus_clk_en, o_clear_imask, o_stack_start, o_active_debug_mode;
   logic                    o_mem_access, o_ctrl_reg_access, o_cpu_reg_rd, o_cpu_reg_wr;
   logic                    o_step, o_low_pwr_err;
   int                      miscompares = 0;
   int                      num_checks = 0;
   // mode outputs: cpu clk, bus clk, debug, clear mask, stack start, core reset
   wire logic [5:0] st = {o_cpu_clk_en, o_bus_clk_en, o_active_debug_mode,
                          o_clear_imask, o_stack_start, o_core_reset};
   // command effect strobes
   wire logic [5:0] strb = {o_mem_access, o_ctrl_reg_access, o_cpu_reg_rd,
                            o_cpu_reg_wr, o_step, o_low_pwr_err};

   // ***************************************************************
   // clock, instances
   // ***************************************************************
   initial begin
      forever #5 i_mclk = ~i_mclk;
   end

   dbgm_host_model host (.i_mclk(i_mclk), .i_cmd_accept(o_cmd_accept),
      .i_cmd_ignore(o_cmd_ignore), .o_mode_select_pin(ms), .o_cmd_valid(cmd_valid), .o_cmd(cmd));

   dbgm_mode_ctrl dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_mode_select_pin(ms), .i_pin_reset(i_pin_reset), .i_cmd_valid(cmd_valid),
      .i_cmd(cmd), .o_cmd_accept(o_cmd_accept), .o_cmd_ignore(o_cmd_ignore),
      .i_wait_exec(i_wait_exec), .i_stop_exec(i_stop_exec), .i_irq(i_irq),
      .o_core_reset(o_core_reset), .o_cpu_clk_en(o_cpu_clk_en), .o_bus_clk_en(o_bus_clk_en),
      .o_clear_imask(o_clear_imask), .o_stack_start(o_stack_start),
      .o_active_debug_mode(o_active_debug_mode), .o_mem_access(o_mem_access),
      .o_ctrl_reg_access(o_ctrl_reg_access), .o_cpu_reg_rd(o_cpu_reg_rd),
      .o_cpu_reg_wr(o_cpu_reg_wr), .o_step(o_step), .o_low_pwr_err(o_low_pwr_err));

   // ***************************************************************
   // tasks
   // ***************************************************************
   // expected strobe per command class; status command errs when clock is off
   function automatic logic [5:0] exp_strb(input dbgm_cmd_e c, input logic lowp);
      case (c)
         DBGM_C_MEM:      return 6'h20;
         DBGM_C_MEM_STAT: return lowp ? 6'h01 : 6'h20;
         DBGM_C_CTRL_REG: return 6'h10;
         DBGM_C_CPU_RD:   return 6'h08;
         DBGM_C_CPU_WR:   return 6'h04;
         DBGM_C_STEP:     return 6'h02;
         default:         return 6'h00;
      endcase
   endfunction

   // power-on reset with a chosen mode select level
   task automatic do_reset(input logic lvl);
      host.set_ms(lvl);
      i_resetn <= 1'b0;
      repeat (10) @(posedge i_mclk);
      i_resetn <= 1'b1;
      repeat (2) @(posedge i_mclk);
      #1;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr    <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge i_mclk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd   <= 1'b0;
      #1;
      `CHK("read data", exp, o_rdata)
   endtask

   // one cycle of cpu events: wait, stop, pin reset, interrupt
   task automatic ev(input logic [3:0] v, input logic [5:0] exp);
      @(posedge i_mclk);
      {i_wait_exec, i_stop_exec, i_pin_reset, i_irq} <= v;
      @(posedge i_mclk);
      {i_wait_exec, i_stop_exec, i_pin_reset, i_irq} <= 4'h0;
      #1;
      `CHK("mode outputs", exp, st)
   endtask

   // send a command, check admission and the strobe a cycle later
   task automatic dcmd(input dbgm_cmd_e c, input logic exp, input logic lowp);
      host.send(c, acc, ign);
      `CHK("accept", exp, acc)
      `CHK("ignore", ~exp, ign)
      #1;
      `CHK("strobes", exp ? exp_strb(c, lowp) : 6'h00, strb)
   endtask

   task automatic conclude();
      $display("checks %0d, miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ***************************************************************
   // tests
   // ***************************************************************
   initial begin
      do_reset(1'b1);
      `CHK("after reset", 6'h30, st)
      rd(`DBGM_OFS_STATUS, 8'h01);
      rd(`DBGM_OFS_OPTS, `DBGM_OPTS_RST);
      rd(`DBGM_OFS_FORCE, 8'h00);
      rd(4'hf, 8'h00);
      for (int i = 0; i < 8; i++) if (i != 3) dcmd(dbgm_cmd_e'(i), i < 3, 1'b0);
      ev(4'h8, 6'h14);
      rd(`DBGM_OFS_STATUS, 8'h02);
      for (int i = 0; i < 8; i++) if (i != 3) dcmd(dbgm_cmd_e'(i), i == 1, 1'b1);
      ev(4'h1, 6'h32);
      ev(4'h8, 6'h14);
      dcmd(DBGM_C_ENTER_DBG, 1'b1, 1'b0);
      `CHK("wake to debug", 6'h38, st)
      rd(`DBGM_OFS_STATUS, 8'h14);
      for (int i = 0; i < 7; i++) if (i != 3) dcmd(dbgm_cmd_e'(i), 1'b1, 1'b0);
      dcmd(DBGM_C_RESUME, 1'b1, 1'b0);
      `CHK("resume", 6'h30, st)
      ev(4'h4, 6'h30);
      wr(`DBGM_OFS_OPTS, 8'h20);
      rd(`DBGM_OFS_OPTS, 8'h20);
      ev(4'h4, 6'h00);
      dcmd(DBGM_C_MEM_STAT, 1'b1, 1'b1);
      dcmd(DBGM_C_ENTER_DBG, 1'b0, 1'b0);
      ev(4'h1, 6'h32);
      wr(`DBGM_OFS_FORCE, 8'h01);
      `CHK("force with select high", 6'h30, st)
      host.set_ms(1'b0);
      wr(`DBGM_OFS_FORCE, 8'h01);
      `CHK("forced debug reset", 6'h39, st)
      rd(`DBGM_OFS_STATUS, 8'h04);
      ev(4'h2, 6'h31);
      wr(`DBGM_OFS_FORCE, 8'h01);
      `CHK("force before entry", 6'h30, st)
      do_reset(1'b0);
      `CHK("power-on select low", 6'h38, st)
      conclude();
   end

   // watchdog: the sequence needs well under a thousand cycles
   initial begin
      #100000;
      miscompares++;
      conclude();
   end
endmodule // dbgm_mode_ctrl_test
